//--- logic/tpom_monitor.sv
// Overview of operation
// - Outside TU3, remote defect status follows V5 defect bit after 5/10 multiframes.
// - In TU3, remote defect status follows G1 defect bit after 5/10 frames.
// - Outside TU3, remote failure status follows V5 failure bit, same filter.
// - Extended defect code loads after 5/10 identical consecutive receptions.
// - Outside TU3, source select picks V5 bits or Z7 extended code.
// - In TU3, source select picks G1 single bit or G1 extended code.
// - Mismatch status is high while accepted label differs from expected.
// - Instability counter increments when label differs from previous multiframe.
// - Five equal labels clear counter; unstable status set at five.
// - Path defect indication forced, or raised when label equals defect code.
// - Terminate picks AIS conditions from control; else loss of pointer/multiframe.
// - Expected label uses eight bits in TU3, low three otherwise.
// - Accepted label reports eight bits in TU3, low three otherwise.
// - Count BIP-8 in TU3, BIP-2 otherwise; count wraps.
// - Trigger write snapshots count within 10 us and restarts accumulation.
// - Outside TU3 only eleven count bits valid, upper five read zero.
// - Parity errors counted per bit or per block by select bit.
// - Block mode adds one for any wrong bits, else one per bit.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tpom_monitor
	import tpom_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [11:2] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             irq,
	input  wire logic        ohStb,
	input  wire logic [7:0]  v5Byte,
	input  wire logic [7:0]  z7Byte,
	input  wire logic [7:0]  g1Byte,
	input  wire logic [7:0]  c2Byte,
	input  wire logic        bipStb,
	input  wire logic [7:0]  bipErr,
	input  wire logic        lopAlarm,
	input  wire logic        lomAlarm,
	output logic             pathDefectInd,
	output logic             aisInsert
);
	// ************************************************************
	// Declarations
	// ************************************************************
	logic        ack_q, ack_d;
	logic [7:0]  rdat_q, rdat_d;
	logic [7:0]  config_q, config_d;
	logic        srcSel_q, srcSel_d;
	logic        term_q, term_d;
	logic        force_q, force_d;
	logic [7:0]  expect_q, expect_d;
	logic [7:0]  mode_q, mode_d;
	logic [7:0]  aisCtrl_q, aisCtrl_d;
	logic [NUM_EVENTS-1:0] intStat_q, intStat_d;
	logic [NUM_EVENTS-1:0] intMask_q, intMask_d;
	logic        irq_q, irq_d;
	logic [7:0]  prevLabel_q, prevLabel_d;
	logic [7:0]  accepted_q, accepted_d;
	logic [7:0]  lastLabel_q, lastLabel_d;
	logic [2:0]  sameCnt_q, sameCnt_d;
	logic [2:0]  unstCnt_q, unstCnt_d;
	logic        unstable_q, unstable_d;
	logic        mismatch_q, mismatch_d;
	logic        pdi_q, pdi_d;
	logic        ais_q, ais_d;
	logic [15:0] accum_q, accum_d;
	logic [15:0] count_q, count_d;
	logic        busReq, wrEn, trigger;
	logic        tu3, longSel, blockSel;
	logic [7:0]  rxLabel, expectEff, acceptEff;
	logic        rdiStat, rfiStat;
	logic [2:0]  erdiStat;
	logic        rdiChg, rfiChg, erdiChg;
	logic [NUM_EVENTS-1:0] events;
	logic [3:0]  bipInc;

	function automatic logic [3:0] bip_add(input logic [7:0] err, input logic wide, input logic block);
		logic [7:0] m;
		logic [3:0] n;
		m = wide ? err : {6'h00, err[1:0]};
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, m[i]};
		end
		return block ? {3'h0, |m} : n;
	endfunction

	function automatic logic [7:0] label_view(input logic [7:0] lbl, input logic wide);
		return wide ? lbl : {5'h00, lbl[2:0]};
	endfunction

	assign tu3      = mode_q[MODE_TU3_BIT];
	assign longSel  = mode_q[MODE_PERS_BIT];
	assign blockSel = config_q[CFG_BLOCK_BIT];
	assign busReq   = cyc_i & stb_i & ~ack_q;
	assign wrEn     = busReq & we_i & sel_i[0];
	assign trigger  = wrEn && adr_i == IDX_TRIGGER;

	// ************************************************************
	// Remote defect filters
	// ************************************************************
	tpom_persist #(.W(1)) rdiFilter (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.sampleStb (ohStb & ~srcSel_q),
		.sample    (tu3 ? g1Byte[G1_RDI_BIT] : v5Byte[V5_RDI_BIT]),
		.longSel   (longSel),
		.filtered  (rdiStat),
		.changed   (rdiChg)
	);

	tpom_persist #(.W(1)) rfiFilter (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.sampleStb (ohStb & ~srcSel_q & ~tu3),
		.sample    (v5Byte[V5_RFI_BIT]),
		.longSel   (longSel),
		.filtered  (rfiStat),
		.changed   (rfiChg)
	);

	tpom_persist #(.W(3)) erdiFilter (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.sampleStb (ohStb & srcSel_q),
		.sample    (tu3 ? g1Byte[G1_ERDI_LSB +: 3] : z7Byte[Z7_ERDI_LSB +: 3]),
		.longSel   (longSel),
		.filtered  (erdiStat),
		.changed   (erdiChg)
	);

	// ************************************************************
	// Label, alarm and parity logic
	// ************************************************************
	always_comb begin
		rxLabel   = tu3 ? c2Byte : {5'h00, v5Byte[V5_LABEL_LSB +: 3]};
		expectEff = label_view(expect_q, tu3);
		acceptEff = label_view(accepted_q, tu3);
		bipInc    = bip_add(bipErr, tu3, blockSel);
		prevLabel_d = prevLabel_q;
		accepted_d  = accepted_q;
		lastLabel_d = lastLabel_q;
		sameCnt_d   = sameCnt_q;
		unstCnt_d   = unstCnt_q;
		if (ohStb) begin
			lastLabel_d = rxLabel;
			prevLabel_d = rxLabel;
			if (rxLabel != prevLabel_q) begin
				sameCnt_d = 3'h1;
				// Saturate above five so the alarm does not fall on wrap
				unstCnt_d = (unstCnt_q == 3'h7) ? unstCnt_q : unstCnt_q + 3'h1;
			end else if (sameCnt_q != STABLE_COUNT) begin
				sameCnt_d = sameCnt_q + 3'h1;
			end
			if (sameCnt_d == STABLE_COUNT) begin
				unstCnt_d  = 3'h0;
				accepted_d = rxLabel;
			end
		end
		mismatch_d = acceptEff != expectEff;
		if (unstCnt_d >= UNSTABLE_COUNT) begin
			unstable_d = 1'b1;
		end else if (unstCnt_d == 3'h0) begin
			unstable_d = 1'b0;
		end else begin
			unstable_d = unstable_q;
		end
		pdi_d = force_q | (lastLabel_q == {5'h00, mode_q[MODE_PDI_LSB +: 3]});
		if (term_q) begin
			ais_d = (aisCtrl_q[AIS_LOP] & lopAlarm) | (aisCtrl_q[AIS_LOM] & lomAlarm)
				| (aisCtrl_q[AIS_MISM] & mismatch_q) | (aisCtrl_q[AIS_UNST] & unstable_q)
				| (aisCtrl_q[AIS_PDI] & pdi_q) | (aisCtrl_q[AIS_RDI] & rdiStat);
		end else begin
			ais_d = lopAlarm | lomAlarm;
		end
		accum_d = accum_q;
		count_d = count_q;
		if (trigger) begin
			// Errors of the trigger cycle open the new period, none are lost
			count_d = tu3 ? accum_q : {5'h00, accum_q[NARROW_COUNT_BITS-1:0]};
			accum_d = bipStb ? {12'h000, bipInc} : 16'h0000;
		end else if (bipStb) begin
			accum_d = accum_q + {12'h000, bipInc};
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prevLabel_q <= BYTE_RESET;
			accepted_q  <= BYTE_RESET;
			lastLabel_q <= BYTE_RESET;
			sameCnt_q   <= 3'h0;
			unstCnt_q   <= 3'h0;
			unstable_q  <= 1'b0;
			mismatch_q  <= 1'b0;
			pdi_q       <= 1'b0;
			ais_q       <= 1'b0;
			accum_q     <= 16'h0000;
			count_q     <= 16'h0000;
		end else begin
			prevLabel_q <= prevLabel_d;
			accepted_q  <= accepted_d;
			lastLabel_q <= lastLabel_d;
			sameCnt_q   <= sameCnt_d;
			unstCnt_q   <= unstCnt_d;
			unstable_q  <= unstable_d;
			mismatch_q  <= mismatch_d;
			pdi_q       <= pdi_d;
			ais_q       <= ais_d;
			accum_q     <= accum_d;
			count_q     <= count_d;
		end
	end

	// ************************************************************
	// Register bus and interrupt
	// ************************************************************
	always_comb begin
		events = '0;
		events[EV_RDI]   = rdiChg;
		events[EV_RFI]   = rfiChg;
		events[EV_ERDI]  = erdiChg;
		events[EV_MISM]  = mismatch_d != mismatch_q;
		events[EV_UNST]  = unstable_d != unstable_q;
		events[EV_LABEL] = accepted_d != accepted_q;
		ack_d     = busReq;
		config_d  = config_q;
		srcSel_d  = srcSel_q;
		term_d    = term_q;
		force_d   = force_q;
		expect_d  = expect_q;
		mode_d    = mode_q;
		aisCtrl_d = aisCtrl_q;
		intMask_d = intMask_q;
		intStat_d = intStat_q;
		if (wrEn) begin
			unique case (adr_i)
				IDX_CONFIG: config_d = dat_i[7:0];
				IDX_ALARM: begin
					srcSel_d = dat_i[ALM_SRC_BIT];
					term_d   = dat_i[ALM_TERM_BIT];
					force_d  = dat_i[ALM_FORCE_BIT];
				end
				IDX_EXPECT:   expect_d  = dat_i[7:0];
				IDX_MODE:     mode_d    = dat_i[7:0];
				IDX_AIS_CTRL: aisCtrl_d = dat_i[7:0];
				IDX_INT_MASK: intMask_d = dat_i[NUM_EVENTS-1:0];
				IDX_INT_STAT: intStat_d = intStat_q & ~dat_i[NUM_EVENTS-1:0];
				default: ;
			endcase
		end
		// Set wins over a clear in the same cycle
		intStat_d = intStat_d | events;
		irq_d = |(intStat_q & intMask_q);
		rdat_d = rdat_q;
		if (busReq) begin
			unique case (adr_i)
				IDX_CONFIG:   rdat_d = config_q;
				IDX_ALARM:    rdat_d = {srcSel_q, term_q, force_q, unstable_q, mismatch_q,
					srcSel_q ? erdiStat : {1'b0, rfiStat & ~tu3, rdiStat}};
				IDX_EXPECT:   rdat_d = expect_q;
				IDX_ACCEPT:   rdat_d = acceptEff;
				IDX_CNT_LO:   rdat_d = count_q[7:0];
				IDX_CNT_HI:   rdat_d = tu3 ? count_q[15:8] : {5'h00, count_q[10:8]};
				IDX_MODE:     rdat_d = mode_q;
				IDX_AIS_CTRL: rdat_d = aisCtrl_q;
				IDX_INT_STAT: rdat_d = {2'h0, intStat_q};
				IDX_INT_MASK: rdat_d = {2'h0, intMask_q};
				default:      rdat_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q     <= 1'b0;
			rdat_q    <= BYTE_RESET;
			config_q  <= CONFIG_RESET;
			srcSel_q  <= 1'b0;
			term_q    <= 1'b0;
			force_q   <= 1'b0;
			expect_q  <= BYTE_RESET;
			mode_q    <= BYTE_RESET;
			aisCtrl_q <= BYTE_RESET;
			intMask_q <= '0;
			intStat_q <= '0;
			irq_q     <= 1'b0;
		end else begin
			ack_q     <= ack_d;
			rdat_q    <= rdat_d;
			config_q  <= config_d;
			srcSel_q  <= srcSel_d;
			term_q    <= term_d;
			force_q   <= force_d;
			expect_q  <= expect_d;
			mode_q    <= mode_d;
			aisCtrl_q <= aisCtrl_d;
			intMask_q <= intMask_d;
			intStat_q <= intStat_d;
			irq_q     <= irq_d;
		end
	end

	assign ack_o         = ack_q;
	assign dat_o         = {24'h000000, rdat_q};
	assign irq           = irq_q;
	assign pathDefectInd = pdi_q;
	assign aisInsert     = ais_q;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence busAsk;
		cyc_i && stb_i && !ack_q;
	endsequence
	sequence busDone;
		ack_q ##1 !ack_q;
	endsequence

	bus_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
		busAsk |=> busDone)
		else $error("bus request not answered in one cycle");
	label_mismatch_a: assert property (@(posedge mclk) disable iff (!rst_n)
		##1 mismatch_q == ($past(acceptEff) != $past(expectEff)))
		else $error("mismatch status wrong");
	label_unstable_a: assert property (@(posedge mclk) disable iff (!rst_n)
		unstCnt_q >= UNSTABLE_COUNT |-> unstable_q)
		else $error("unstable status missing at count five");
	label_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ohStb && rxLabel != prevLabel_q && unstCnt_q < 3'h4 && sameCnt_d != STABLE_COUNT
		|=> unstCnt_q == $past(unstCnt_q) + 3'h1)
		else $error("instability counter did not advance");
	defect_force_a: assert property (@(posedge mclk) disable iff (!rst_n)
		force_q |=> pdi_q)
		else $error("forced path defect not raised");
	ais_through_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!term_q |=> ais_q == $past(lopAlarm || lomAlarm))
		else $error("through traffic AIS wrong");
	count_snap_a: assert property (@(posedge mclk) disable iff (!rst_n)
		trigger && !bipStb |=> count_q[10:0] == $past(accum_q[10:0]) && accum_q == 16'h0000)
		else $error("snapshot or restart wrong");
	count_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!trigger |=> $stable(count_q))
		else $error("count changed between triggers");
	count_narrow_a: assert property (@(posedge mclk) disable iff (!rst_n)
		busAsk and (!we_i && adr_i == IDX_CNT_HI && !tu3) |=> rdat_q[7:3] == 5'h00)
		else $error("upper count bits not zero");
	block_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
		bipStb && !trigger && blockSel && !tu3 && (|bipErr[1:0]) |=> accum_q == $past(accum_q) + 16'h0001)
		else $error("block mode did not add one");
	irq_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
		##1 irq_q == |($past(intStat_q) & $past(intMask_q)))
		else $error("interrupt level wrong");
endmodule
`default_nettype wire

//--- logic/tpom_pkg.sv
package tpom_pkg;
	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [9:0] IDX_CONFIG   = 10'h100;
	localparam logic [9:0] IDX_ALARM    = 10'h101;
	localparam logic [9:0] IDX_EXPECT   = 10'h102;
	localparam logic [9:0] IDX_ACCEPT   = 10'h103;
	localparam logic [9:0] IDX_CNT_LO   = 10'h104;
	localparam logic [9:0] IDX_CNT_HI   = 10'h105;
	localparam logic [9:0] IDX_MODE     = 10'h110;
	localparam logic [9:0] IDX_TRIGGER  = 10'h111;
	localparam logic [9:0] IDX_INT_STAT = 10'h112;
	localparam logic [9:0] IDX_INT_MASK = 10'h113;
	localparam logic [9:0] IDX_AIS_CTRL = 10'h114;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CFG_BLOCK_BIT  = 5;
	localparam int ALM_SRC_BIT    = 7;
	localparam int ALM_TERM_BIT   = 6;
	localparam int ALM_FORCE_BIT  = 5;
	localparam int ALM_UNST_BIT   = 4;
	localparam int ALM_MISM_BIT   = 3;
	localparam int MODE_TU3_BIT   = 0;
	localparam int MODE_PERS_BIT  = 1;
	localparam int MODE_PDI_LSB   = 2;
	localparam int V5_RDI_BIT     = 0;
	localparam int V5_RFI_BIT     = 4;
	localparam int V5_LABEL_LSB   = 1;
	localparam int Z7_ERDI_LSB    = 1;
	localparam int G1_RDI_BIT     = 3;
	localparam int G1_ERDI_LSB    = 1;
	localparam int EV_RDI         = 0;
	localparam int EV_RFI         = 1;
	localparam int EV_ERDI        = 2;
	localparam int EV_MISM        = 3;
	localparam int EV_UNST        = 4;
	localparam int EV_LABEL       = 5;
	localparam int NUM_EVENTS     = 6;
	localparam int AIS_LOP        = 0;
	localparam int AIS_LOM        = 1;
	localparam int AIS_MISM       = 2;
	localparam int AIS_UNST       = 3;
	localparam int AIS_PDI        = 4;
	localparam int AIS_RDI        = 5;

	// ************************************************************
	// Reset values and counts
	// ************************************************************
	localparam logic [7:0] CONFIG_RESET = 8'hC0;
	localparam logic [7:0] BYTE_RESET   = 8'h00;
	localparam logic [3:0] PERSIST_SHORT = 4'h5;
	localparam logic [3:0] PERSIST_LONG  = 4'hA;
	localparam logic [2:0] STABLE_COUNT  = 3'h5;
	localparam logic [2:0] UNSTABLE_COUNT = 3'h5;
	localparam int NARROW_COUNT_BITS = 11;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int SNAP_LIMIT_NS  = 10000;
	localparam int SNAP_LIMIT_CYC = (SNAP_LIMIT_NS * 1000) / CLK_PERIOD_PS;
endpackage

//--- logic/tpom_persist.sv
`timescale 1ns/1ps
`default_nettype none
module tpom_persist
	import tpom_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         sampleStb,
	input  wire logic [W-1:0] sample,
	input  wire logic         longSel,
	output logic      [W-1:0] filtered,
	output logic              changed
);
	logic [W-1:0] cand_q, cand_d, out_q, out_d;
	logic [3:0]   cnt_q, cnt_d;
	logic         chg_q, chg_d;
	logic [3:0]   need;

	// ************************************************************
	// Consecutive-sample filter
	// ************************************************************
	always_comb begin
		need  = longSel ? PERSIST_LONG : PERSIST_SHORT;
		cand_d = cand_q;
		cnt_d  = cnt_q;
		out_d  = out_q;
		chg_d  = 1'b0;
		if (sampleStb) begin
			if (sample == cand_q) begin
				// Saturate so a long run never wraps back below the limit
				cnt_d = (cnt_q == PERSIST_LONG) ? cnt_q : cnt_q + 4'h1;
			end else begin
				cand_d = sample;
				cnt_d  = 4'h1;
			end
			if (cnt_d >= need && cand_d != out_q) begin
				out_d = cand_d;
				chg_d = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cand_q <= '0;
			cnt_q  <= 4'h0;
			out_q  <= '0;
			chg_q  <= 1'b0;
		end else begin
			cand_q <= cand_d;
			cnt_q  <= cnt_d;
			out_q  <= out_d;
			chg_q  <= chg_d;
		end
	end

	assign filtered = out_q;
	assign changed  = chg_q;

	// ************************************************************
	// Checks
	// ************************************************************
	filter_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!sampleStb |=> $stable(out_q))
		else $error("filtered value changed without a sample");
	filter_run_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sampleStb && sample == cand_q && cnt_q == (longSel ? PERSIST_LONG : PERSIST_SHORT) - 4'h1
		|=> out_q == $past(sample))
		else $error("persistent sample did not load");
endmodule
`default_nettype wire

//--- bench/tpom_stream_src.sv
`timescale 1ns/1ps
`default_nettype none
module tpom_stream_src (
	input  wire logic       mclk,
	output logic            ohStb,
	output logic      [7:0] v5Byte,
	output logic      [7:0] z7Byte,
	output logic      [7:0] g1Byte,
	output logic      [7:0] c2Byte,
	output logic            bipStb,
	output logic      [7:0] bipErr
);
	// ************************************************************
	// Overhead and parity source
	// ************************************************************
	initial begin
		ohStb  = 1'b0;
		bipStb = 1'b0;
		v5Byte = 8'h00;
		z7Byte = 8'h00;
		g1Byte = 8'h00;
		c2Byte = 8'h00;
		bipErr = 8'h00;
	end

	// Bytes inverted between strobes so stale values never look valid
	task automatic frames(input logic [7:0] v5, z7, g1, c2, input int n);
		repeat (n) begin
			@(posedge mclk);
			ohStb  <= 1'b1;
			v5Byte <= v5;
			z7Byte <= z7;
			g1Byte <= g1;
			c2Byte <= c2;
			@(posedge mclk);
			ohStb  <= 1'b0;
			v5Byte <= ~v5;
			z7Byte <= ~z7;
			g1Byte <= ~g1;
			c2Byte <= ~c2;
		end
	endtask

	task automatic bips(input logic [7:0] e, input int n);
		repeat (n) begin
			@(posedge mclk);
			bipStb <= 1'b1;
			bipErr <= e;
			@(posedge mclk);
			bipStb <= 1'b0;
			bipErr <= ~e;
		end
	endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import tpom_pkg::*;
;
	// ************************************************************
	// Signals
	// ************************************************************
	logic        mclk, rst_n, wbCyc, wbStb, wbWe, lopAlarm, lomAlarm;
	logic [9:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatW, wbDatR;
	logic        ack, irq, pathDefectInd, aisInsert, ohStb, bipStb;
	logic [7:0]  v5Byte, z7Byte, g1Byte, c2Byte, bipErr;
	int          err_total, compares, n;

	tpom_monitor u_dut (.mclk(mclk), .rst_n(rst_n), .cyc_i(wbCyc), .stb_i(wbStb), .we_i(wbWe),
		.adr_i(wbAdr), .sel_i(wbSel), .dat_i(wbDatW), .dat_o(wbDatR), .ack_o(ack), .irq(irq),
		.ohStb(ohStb), .v5Byte(v5Byte), .z7Byte(z7Byte), .g1Byte(g1Byte), .c2Byte(c2Byte),
		.bipStb(bipStb), .bipErr(bipErr), .lopAlarm(lopAlarm), .lomAlarm(lomAlarm),
		.pathDefectInd(pathDefectInd), .aisInsert(aisInsert));

	tpom_stream_src u_src (.mclk(mclk), .ohStb(ohStb), .v5Byte(v5Byte), .z7Byte(z7Byte),
		.g1Byte(g1Byte), .c2Byte(c2Byte), .bipStb(bipStb), .bipErr(bipErr));

	always #2.5 mclk = ~mclk;

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// Ack sampled before the edge's own updates land; only the watchdog ends a wait
	task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] wd, output logic [31:0] rd);
		@(posedge mclk);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= w;
		wbAdr  <= idx;
		wbSel  <= 4'hF;
		wbDatW <= {24'h000000, wd};
		@(posedge mclk);
		while (ack !== 1'b1) begin
			@(posedge mclk);
		end
		rd = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
		logic [31:0] r;
		wb(1'b1, idx, wd, r);
	endtask

	task automatic rdc(input logic [9:0] idx, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] r;
		wb(1'b0, idx, 8'h00, r);
		chk(r & m, exp);
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge mclk);
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ************************************************************
	// Watchdog, 40k cycles against an expected run of some 19k
	// ************************************************************
	initial begin
		#200000;
		err_total++;
		close_out();
	end

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 10'h000;
		wbSel = 4'h0;
		wbDatW = 32'h00000000;
		lopAlarm = 1'b0;
		lomAlarm = 1'b0;
		err_total = 0;
		compares = 0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		rdc(IDX_CONFIG, 32'hFFFFFFFF, 32'h000000C0);
		rdc(IDX_ALARM, 32'h000000E0, 32'h00000000);
		rdc(IDX_EXPECT, 32'hFFFFFFFF, 32'h00000000);
		rdc(IDX_ACCEPT, 32'hFFFFFFFF, 32'h00000000);
		rdc(IDX_CNT_LO, 32'hFFFFFFFF, 32'h00000000);
		rdc(IDX_CNT_HI, 32'hFFFFFFFF, 32'h00000000);
		wr(IDX_EXPECT, 8'hA5);
		rdc(IDX_EXPECT, 32'hFFFFFFFF, 32'h000000A5);
		wr(IDX_ACCEPT, 8'hFF);
		rdc(IDX_ACCEPT, 32'hFFFFFFFF, 32'h00000000);
		rdc(10'h0FF, 32'hFFFFFFFF, 32'h00000000);
		// Defect and failure filters, short then long persistence
		for (int p = 0; p < 2; p++) begin
			n = p ? 10 : 5;
			wr(IDX_MODE, p ? 8'h02 : 8'h00);
			u_src.frames(8'h11, 8'h00, 8'h00, 8'h00, n - 1);
			rdc(IDX_ALARM, 32'h3, 32'h0);
			u_src.frames(8'h11, 8'h00, 8'h00, 8'h00, 1);
			rdc(IDX_ALARM, 32'h3, 32'h3);
			u_src.frames(8'h00, 8'h00, 8'h00, 8'h00, n - 1);
			rdc(IDX_ALARM, 32'h3, 32'h3);
			u_src.frames(8'h00, 8'h00, 8'h00, 8'h00, 1);
			rdc(IDX_ALARM, 32'h3, 32'h0);
		end
		rdc(IDX_INT_STAT, 32'h3, 32'h3);
		chk(irq, 1'b0);
		wr(IDX_INT_MASK, 8'h01);
		tick(2);
		chk(irq, 1'b1);
		wr(IDX_INT_STAT, 8'h3F);
		tick(2);
		chk(irq, 1'b0);
		rdc(IDX_INT_STAT, 32'h3, 32'h0);
		wr(IDX_INT_MASK, 8'h00);
		// Extended code from the Z7 byte
		wr(IDX_MODE, 8'h00);
		wr(IDX_ALARM, 8'h80);
		u_src.frames(8'h00, 8'h0A, 8'h00, 8'h00, 4);
		rdc(IDX_ALARM, 32'h7, 32'h0);
		u_src.frames(8'h00, 8'h0A, 8'h00, 8'h00, 1);
		rdc(IDX_ALARM, 32'h7, 32'h5);
		// TU3: single defect bit, then extended code, from G1
		wr(IDX_MODE, 8'h01);
		wr(IDX_ALARM, 8'h00);
		u_src.frames(8'h00, 8'h00, 8'h08, 8'h00, 5);
		rdc(IDX_ALARM, 32'h1, 32'h1);
		wr(IDX_ALARM, 8'h80);
		u_src.frames(8'h00, 8'h00, 8'h06, 8'h00, 4);
		rdc(IDX_ALARM, 32'h7, 32'h5);
		u_src.frames(8'h00, 8'h00, 8'h06, 8'h00, 1);
		rdc(IDX_ALARM, 32'h7, 32'h3);
		u_src.frames(8'h00, 8'h00, 8'h00, 8'h13, 6);
		rdc(IDX_ACCEPT, 32'hFF, 32'h13);
		wr(IDX_EXPECT, 8'h13);
		rdc(IDX_ALARM, 32'h8, 32'h0);
		wr(IDX_EXPECT, 8'h03);
		rdc(IDX_ALARM, 32'h8, 32'h8);
		// Label stability outside TU3
		wr(IDX_MODE, 8'h00);
		wr(IDX_ALARM, 8'h00);
		u_src.frames(8'h00, 8'h00, 8'h00, 8'h00, 6);
		for (int i = 0; i < 5; i++) begin
			u_src.frames((i % 2) ? 8'h04 : 8'h02, 8'h00, 8'h00, 8'h00, 1);
			if (i == 3) rdc(IDX_ALARM, 32'h10, 32'h00);
		end
		rdc(IDX_ALARM, 32'h10, 32'h10);
		u_src.frames(8'h06, 8'h00, 8'h00, 8'h00, 6);
		rdc(IDX_ALARM, 32'h10, 32'h00);
		rdc(IDX_ACCEPT, 32'hFF, 32'h03);
		wr(IDX_EXPECT, 8'hFB);
		rdc(IDX_ALARM, 32'h8, 32'h0);
		wr(IDX_EXPECT, 8'h05);
		rdc(IDX_ALARM, 32'h8, 32'h8);
		// Path defect indication
		wr(IDX_MODE, 8'h14);
		u_src.frames(8'h0A, 8'h00, 8'h00, 8'h00, 1);
		tick(3);
		chk(pathDefectInd, 1'b1);
		u_src.frames(8'h06, 8'h00, 8'h00, 8'h00, 1);
		tick(3);
		chk(pathDefectInd, 1'b0);
		wr(IDX_ALARM, 8'h20);
		tick(3);
		chk(pathDefectInd, 1'b1);
		// AIS selection, through traffic then terminated
		wr(IDX_ALARM, 8'h00);
		wr(IDX_AIS_CTRL, 8'h00);
		lopAlarm <= 1'b1;
		tick(3);
		chk(aisInsert, 1'b1);
		lopAlarm <= 1'b0;
		lomAlarm <= 1'b1;
		tick(3);
		chk(aisInsert, 1'b1);
		lomAlarm <= 1'b0;
		tick(3);
		chk(aisInsert, 1'b0);
		wr(IDX_ALARM, 8'h40);
		lopAlarm <= 1'b1;
		tick(3);
		chk(aisInsert, 1'b0);
		wr(IDX_AIS_CTRL, 8'h01);
		tick(3);
		chk(aisInsert, 1'b1);
		lopAlarm <= 1'b0;
		// Parity counts, snapshot and restart
		wr(IDX_MODE, 8'h00);
		wr(IDX_TRIGGER, 8'h00);
		u_src.bips(8'h03, 3);
		u_src.bips(8'h01, 1);
		wr(IDX_TRIGGER, 8'h00);
		rdc(IDX_CNT_LO, 32'hFF, 32'h07);
		rdc(IDX_CNT_HI, 32'hFF, 32'h00);
		u_src.bips(8'h02, 3);
		rdc(IDX_CNT_LO, 32'hFF, 32'h07);
		wr(IDX_TRIGGER, 8'h00);
		rdc(IDX_CNT_LO, 32'hFF, 32'h03);
		wr(IDX_CONFIG, 8'hE0);
		u_src.bips(8'h03, 2);
		u_src.bips(8'h02, 1);
		wr(IDX_TRIGGER, 8'h00);
		rdc(IDX_CNT_LO, 32'hFF, 32'h03);
		wr(IDX_CONFIG, 8'hC0);
		u_src.bips(8'h03, 1025);
		wr(IDX_TRIGGER, 8'h00);
		rdc(IDX_CNT_LO, 32'hFF, 32'h02);
		rdc(IDX_CNT_HI, 32'hFF, 32'h00);
		wr(IDX_MODE, 8'h01);
		wr(IDX_TRIGGER, 8'h00);
		u_src.bips(8'hFF, 8448);
		wr(IDX_TRIGGER, 8'h00);
		rdc(IDX_CNT_LO, 32'hFF, 32'h00);
		rdc(IDX_CNT_HI, 32'hFF, 32'h08);
		close_out();
	end
endmodule
`default_nettype wire
